// ### tsl_cfg.svh
`ifndef TSL_CFG_SVH
`define TSL_CFG_SVH

// Clock and prescaler
`define TSL_CLK_HZ          20000000
`define TSL_TICK_MS         1
`define TSL_TICK_CYCLES     ((`TSL_CLK_HZ / 1000) * `TSL_TICK_MS)

// Emergency retry window
`define TSL_RETRY_WINDOW_S  20
`define TSL_RETRY_TRIES     2
`define TSL_RETRY_GAP_MS    ((`TSL_RETRY_WINDOW_S * 1000) / `TSL_RETRY_TRIES)

// Thresholds
`define TSL_HOT_C           8'h55
`define TSL_MOD_MAX_PCT     9'h096
`define TSL_SURGE_DV        8'h3e
`define TSL_LO_230V         9'h0c0
`define TSL_HI_230V         9'h109
`define TSL_LO_400V         9'h14c
`define TSL_HI_400V         9'h1cc

// Register offsets and fields
`define TSL_REG_CTRL        4'h0
`define TSL_REG_FLAGS       4'h4
`define TSL_REG_STATE       4'h8
`define TSL_CTRL_REM_EN     0
`define TSL_CTRL_NOM400     1
`define TSL_CTRL_FRST       2
`define TSL_CTRL_RST        2'h0

// Latched flag positions
`define TSL_F_SUM           0
`define TSL_F_FOLD          1
`define TSL_F_EXC           2
`define TSL_F_PS            3
`define TSL_F_PA            4
`define TSL_F_REFL          5
`define TSL_F_EMER          6
`define TSL_F_HOT           7
`define TSL_F_AUD           8
`define TSL_F_PH            9
`define TSL_F_BLW           12
`define TSL_F_AUX           15
`define TSL_NFLAGS          17

// Synchronised pin positions
`define TSL_P_ON            0
`define TSL_P_OFF           1
`define TSL_P_LV1           2
`define TSL_P_LV2           3
`define TSL_P_MUTE          4
`define TSL_P_FSOK          5
`define TSL_P_ILOK          6
`define TSL_P_FRST          7
`define TSL_NPINS           8

`endif

// ### tsl_pkg.sv
package tsl_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_EMER} tsl_state_t;
    typedef logic [1:0] tsl_level_t;
endpackage

// ### tsl_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsl_cfg.svh"

module tsl_sync #(
    parameter int unsigned WIDTH = `TSL_NPINS
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    // Pins and clean levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] clean_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, clean_q, clean_d;

    // A level counts only once stages two and three agree
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        assign clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
    end

    // Stage one feeds stage two only
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            clean_q <= clean_d;
        end
    end

    assign clean_out = clean_q;
endmodule // tsl_sync

`default_nettype wire

// ### tsl_top.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tsl_cfg.svh"

module tsl_top #(
    parameter int unsigned TICK_CYCLES  = `TSL_TICK_CYCLES,
    parameter int unsigned RETRY_GAP_MS = `TSL_RETRY_GAP_MS
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    // Register port
    input  wire logic [3:0]       addr_in,
    input  wire logic [31:0]      wr_data_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [31:0]      rd_data_out,
    // Command pins, active high
    input  wire logic             front_on_in,
    input  wire logic             front_off_in,
    input  wire logic             remote_lvl1_in,
    input  wire logic             remote_lvl2_in,
    input  wire logic             mute_in,
    input  wire logic             failsafe_ok_in,
    input  wire logic             interlock_ok_in,
    input  wire logic             fault_reset_in,
    // Sensing logic on this clock
    input  wire logic             foldback_req_in,
    input  wire logic             exciter_reduce_in,
    input  wire logic [31:0]      ps_fault_in,
    input  wire logic [31:0]      pa_fault_in,
    input  wire logic             refl_gradual_in,
    input  wire logic             refl_emer_in,
    input  wire logic [7:0]       heatsink_max_in,
    input  wire logic [8:0]       mod_pct_in,
    input  wire logic             adc_clip_in,
    input  wire logic [2:0][8:0]  phase_v_in,
    input  wire logic [2:0]       blower_idle_in,
    input  wire logic [7:0]       surge_dv_in,
    input  wire logic [31:0]      pa_manual_off_in,
    input  wire logic [31:0]      ps_manual_off_in,
    input  wire logic [1:0]       aux_fault_in,
    // Status terminals
    output logic                  level_one_indicator_out,
    output logic                  level_two_indicator_out,
    output logic                  off_ind_out,
    output logic                  mute_ind_out,
    output logic                  failsafe_ind_out,
    output logic                  interlock_ind_out,
    output logic                  fault_summary_out,
    output logic                  power_reduction_flag_out,
    output logic                  exciter_fault_flag_out,
    output logic                  supply_module_fault_flag_out,
    output logic                  amplifier_fault_flag_out,
    output logic                  high_reflection_flag_out,
    output logic                  output_short_open_flag_out,
    output logic                  heatsink_hot_flag_out,
    output logic                  audio_overload_flag_out,
    output logic      [2:0]       phase_flag_out,
    output logic      [2:0]       blower_flag_out,
    output logic                  surge_indicator_out,
    output logic                  module_service_indicator_out,
    output logic                  aux_supply_a_flag_out,
    output logic                  aux_supply_b_flag_out,
    // Transmitter control
    output logic                  tx_on_out,
    output logic                  rf_zero_out,
    output logic                  rf_reduce_out,
    output logic      [1:0]       rf_level_out
);
    import tsl_pkg::*;

    logic [`TSL_NPINS-1:0]  pin_s, prev_q;
    logic [`TSL_NFLAGS-1:0] flags_q, flags_d, set_v;
    logic [1:0]             ctrl_q, ctrl_d;
    logic [31:0]            rd_q, rd_d;
    tsl_state_t             st_q, st_d;
    tsl_level_t             lvl_q, lvl_d;
    logic [1:0]             tries_q, tries_d;
    logic [14:0]            tick_q, tick_d;
    logic [13:0]            gap_q, gap_d;
    logic [10:0]            ind_q, ind_d;
    logic                   tick, on_cmd, off_cmd, turn_on, flt_clr;
    logic                   soft_rst, lv1_rise, lv2_rise, nom400;

    // Command pins cross into the clock domain
    tsl_sync #(.WIDTH(`TSL_NPINS)) u_sync (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .pin_in    ({fault_reset_in, interlock_ok_in, failsafe_ok_in, mute_in,
                     remote_lvl2_in, remote_lvl1_in, front_off_in, front_on_in}),
        .clean_out (pin_s)
    );

    // Button and remote commands act on rising edges, interlock loss as a level; remote levels need remote enable
    assign lv1_rise = pin_s[`TSL_P_LV1] & ~prev_q[`TSL_P_LV1] & ctrl_q[`TSL_CTRL_REM_EN];
    assign lv2_rise = pin_s[`TSL_P_LV2] & ~prev_q[`TSL_P_LV2] & ctrl_q[`TSL_CTRL_REM_EN];
    assign on_cmd   = (pin_s[`TSL_P_ON] & ~prev_q[`TSL_P_ON]) | lv1_rise | lv2_rise;
    assign off_cmd  = (pin_s[`TSL_P_OFF] & ~prev_q[`TSL_P_OFF])
                    | ~pin_s[`TSL_P_ILOK];
    assign nom400   = ctrl_q[`TSL_CTRL_NOM400];
    // Reset pin is taken on its edge; its 50 ms width is the remote's job
    assign soft_rst = wr_in && (addr_in == `TSL_REG_CTRL) && wr_data_in[`TSL_CTRL_FRST];
    assign flt_clr  = (pin_s[`TSL_P_FRST] & ~prev_q[`TSL_P_FRST] & ctrl_q[`TSL_CTRL_REM_EN])
                    | soft_rst | turn_on;
    assign tick     = (tick_q == 15'(TICK_CYCLES - 1));

    // Prescaler gives a millisecond tick for the retry spacing
    always_comb begin
        tick_d = tick ? 15'h0000 : tick_q + 15'h0001;
    end

    // On/off sequencing, level memory and emergency retries
    always_comb begin
        st_d    = st_q;
        lvl_d   = lvl_q;
        tries_d = tries_q;
        gap_d   = gap_q;
        turn_on = 1'b0;
        if (lv1_rise) begin
            lvl_d = 2'h1;
        end else if (lv2_rise) begin
            lvl_d = 2'h2;
        end
        case (st_q)
            ST_OFF: begin
                if (on_cmd && pin_s[`TSL_P_ILOK]) begin
                    st_d    = ST_ON;
                    turn_on = 1'b1;
                    tries_d = 2'h0;
                end
            end
            ST_ON: begin
                if (off_cmd) begin
                    st_d = ST_OFF;
                end else if (refl_emer_in) begin
                    gap_d = 14'h0000;
                    st_d  = (tries_q == 2'(`TSL_RETRY_TRIES)) ? ST_OFF : ST_EMER;
                end
            end
            ST_EMER: begin
                if (off_cmd) begin
                    st_d = ST_OFF;
                end else if (gap_q == 14'(RETRY_GAP_MS)) begin
                    st_d    = ST_ON;
                    tries_d = tries_q + 2'h1;
                end else if (tick) begin
                    gap_d = gap_q + 14'h0001;
                end
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
    end

    // Fault causes; the summary takes any of them
    always_comb begin
        set_v = '0;
        set_v[`TSL_F_FOLD] = foldback_req_in | refl_gradual_in | exciter_reduce_in;
        set_v[`TSL_F_EXC]  = exciter_reduce_in;
        set_v[`TSL_F_PS]   = |ps_fault_in;
        set_v[`TSL_F_PA]   = |pa_fault_in;
        set_v[`TSL_F_REFL] = refl_gradual_in;
        set_v[`TSL_F_EMER] = refl_emer_in;
        set_v[`TSL_F_HOT]  = heatsink_max_in > `TSL_HOT_C;
        set_v[`TSL_F_AUD]  = (mod_pct_in > `TSL_MOD_MAX_PCT) | adc_clip_in;
        for (int p = 0; p < 3; p++) begin
            set_v[`TSL_F_PH + p] = nom400 ?
                ((phase_v_in[p] < `TSL_LO_400V) || (phase_v_in[p] > `TSL_HI_400V)) :
                ((phase_v_in[p] < `TSL_LO_230V) || (phase_v_in[p] > `TSL_HI_230V));
        end
        set_v[`TSL_F_BLW +: 3] = blower_idle_in;
        set_v[`TSL_F_AUX +: 2] = aux_fault_in;
        set_v[`TSL_F_SUM]      = |set_v[`TSL_NFLAGS-1:1];
    end

    // Each latch: a new cause wins over a clear in the same cycle
    genvar f;
    for (f = 0; f < `TSL_NFLAGS; f++) begin : g_flag
        assign flags_d[f] = set_v[f] | (flags_q[f] & ~flt_clr);
    end

    // Indicators, unlatched except RF reduce from the reflection latch, registered so terminals never glitch
    always_comb begin
        ind_d    = '0;
        ind_d[0] = (st_q == ST_ON) && (lvl_q == 2'h1);
        ind_d[1] = (st_q == ST_ON) && (lvl_q == 2'h2);
        ind_d[2] = (st_q == ST_OFF);
        ind_d[3] = pin_s[`TSL_P_MUTE];
        ind_d[4] = ~pin_s[`TSL_P_FSOK];
        ind_d[5] = ~pin_s[`TSL_P_ILOK];
        ind_d[6] = surge_dv_in > `TSL_SURGE_DV;
        ind_d[7] = (st_q != ST_OFF) && |{pa_manual_off_in, ps_manual_off_in};
        // Mute and failsafe only zero RF; level memory is kept
        ind_d[8] = (st_q != ST_ON) | pin_s[`TSL_P_MUTE] | ~pin_s[`TSL_P_FSOK];
        ind_d[9] = flags_q[`TSL_F_REFL];
        ind_d[10] = (st_d == ST_ON);
    end

    // Register port: write control, read back state and flags
    always_comb begin
        ctrl_d = ctrl_q;
        rd_d   = 32'h0000_0000;
        if (wr_in && (addr_in == `TSL_REG_CTRL)) begin
            ctrl_d = wr_data_in[1:0];
        end
        if (rd_in) begin
            case (addr_in)
                `TSL_REG_CTRL:  rd_d = {30'h0, ctrl_q};
                `TSL_REG_FLAGS: rd_d = {15'h0, flags_q};
                `TSL_REG_STATE: rd_d = {26'h0, tries_q, lvl_q, st_q};
                default:        rd_d = 32'h0000_0000;
            endcase
        end
    end

    // State registers; power-on reset clears every latch
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_q  <= '0;
            flags_q <= '0;
            ctrl_q  <= `TSL_CTRL_RST;
            rd_q    <= 32'h0000_0000;
            st_q    <= ST_OFF;
            lvl_q   <= 2'h1;
            tries_q <= 2'h0;
            tick_q  <= 15'h0000;
            gap_q   <= 14'h0000;
            ind_q   <= 11'h004;
        end else begin
            prev_q  <= pin_s;
            flags_q <= flags_d;
            ctrl_q  <= ctrl_d;
            rd_q    <= rd_d;
            st_q    <= st_d;
            lvl_q   <= lvl_d;
            tries_q <= tries_d;
            tick_q  <= tick_d;
            gap_q   <= gap_d;
            ind_q   <= ind_d;
        end
    end

    // Outputs straight from flops
    assign rd_data_out                  = rd_q;
    assign level_one_indicator_out      = ind_q[0];
    assign level_two_indicator_out      = ind_q[1];
    assign off_ind_out                  = ind_q[2];
    assign mute_ind_out                 = ind_q[3];
    assign failsafe_ind_out             = ind_q[4];
    assign interlock_ind_out            = ind_q[5];
    assign surge_indicator_out          = ind_q[6];
    assign module_service_indicator_out = ind_q[7];
    assign rf_zero_out                  = ind_q[8];
    assign rf_reduce_out                = ind_q[9];
    assign fault_summary_out            = flags_q[`TSL_F_SUM];
    assign power_reduction_flag_out     = flags_q[`TSL_F_FOLD];
    assign exciter_fault_flag_out       = flags_q[`TSL_F_EXC];
    assign supply_module_fault_flag_out = flags_q[`TSL_F_PS];
    assign amplifier_fault_flag_out     = flags_q[`TSL_F_PA];
    assign high_reflection_flag_out     = flags_q[`TSL_F_REFL];
    assign output_short_open_flag_out   = flags_q[`TSL_F_EMER];
    assign heatsink_hot_flag_out        = flags_q[`TSL_F_HOT];
    assign audio_overload_flag_out      = flags_q[`TSL_F_AUD];
    assign phase_flag_out               = flags_q[`TSL_F_PH +: 3];
    assign blower_flag_out              = flags_q[`TSL_F_BLW +: 3];
    assign aux_supply_a_flag_out        = flags_q[`TSL_F_AUX];
    assign aux_supply_b_flag_out        = flags_q[`TSL_F_AUX + 1];
    assign tx_on_out                    = ind_q[10];
    assign rf_level_out                 = lvl_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    lvl_ind_a: assert property ((st_q == ST_ON) && (lvl_q == 2'h2) |=>
        level_two_indicator_out && !level_one_indicator_out)
        else $error("level two indicator wrong");
    off_ind_a: assert property ((st_q == ST_OFF) |=> off_ind_out)
        else $error("off indicator low while off");
    mute_zero_a: assert property (pin_s[`TSL_P_MUTE] |=> mute_ind_out && rf_zero_out)
        else $error("mute did not zero RF");
    fs_zero_a: assert property (!pin_s[`TSL_P_FSOK] |=> failsafe_ind_out && rf_zero_out)
        else $error("failsafe did not zero RF");
    fs_resume_a: assert property ((st_q == ST_ON) && pin_s[`TSL_P_FSOK] &&
        !pin_s[`TSL_P_MUTE] |=> !rf_zero_out)
        else $error("RF not restored after failsafe");
    ilk_off_a: assert property (!pin_s[`TSL_P_ILOK] |=>
        (st_q == ST_OFF) && interlock_ind_out)
        else $error("interlock did not switch off");
    stay_off_a: assert property ((st_q == ST_OFF) && !on_cmd |=> (st_q == ST_OFF))
        else $error("left off state without command");
    sum_set_a: assert property ((|set_v[`TSL_NFLAGS-1:1]) |=> fault_summary_out)
        else $error("summary flag not set");
    latch_hold_a: assert property (!flt_clr |=>
        ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("latched flag dropped without clear");
    clr_all_a: assert property (flt_clr && (set_v == '0) |=> (flags_q == '0))
        else $error("fault clear left a flag");
    emer_out_a: assert property ((st_q == ST_ON) && refl_emer_in && !off_cmd &&
        (tries_q == 2'h2) |=> (st_q == ST_OFF) && output_short_open_flag_out)
        else $error("third emergency did not stay off");
    hot_a: assert property ((heatsink_max_in > `TSL_HOT_C) |=> heatsink_hot_flag_out)
        else $error("overtemperature not latched");
    surge_a: assert property ((surge_dv_in > `TSL_SURGE_DV) |=> surge_indicator_out)
        else $error("surge indicator low");

    turn_on_c: cover property ((st_q == ST_OFF) ##1 (st_q == ST_ON));
    retry_c: cover property ((st_q == ST_EMER) ##1 (st_q == ST_ON));
    fs_c: cover property (failsafe_ind_out ##1 !failsafe_ind_out);
endmodule // tsl_top

`default_nettype wire

// ### tsl_remote.sv
`timescale 1ns/1ps
`default_nettype none

module tsl_remote #(
    parameter int unsigned HOLD_CYCLES = 10
) (
    // Clock
    input  wire logic mclk_in,
    // Command terminals toward the transmitter
    output logic      fault_reset_out,
    output logic      lvl1_out,
    output logic      lvl2_out
);
    // Idle low until a command is sent
    initial begin
        fault_reset_out = 1'b0;
        lvl1_out        = 1'b0;
        lvl2_out        = 1'b0;
    end

    // Hold width shortened from the real minimum so the run stays short
    task automatic request_reset();
        @(posedge mclk_in);
        fault_reset_out <= 1'b1;
        repeat (HOLD_CYCLES) @(posedge mclk_in);
        fault_reset_out <= 1'b0;
    endtask

    // Level selection is a held pulse on one terminal
    task automatic select_level(input int n);
        @(posedge mclk_in);
        lvl1_out <= (n == 1);
        lvl2_out <= (n == 2);
        repeat (HOLD_CYCLES) @(posedge mclk_in);
        lvl1_out <= 1'b0;
        lvl2_out <= 1'b0;
    endtask
endmodule // tsl_remote

`default_nettype wire

// ### tsl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module tsl_top_test;
    // Clock, reset and register port
    logic            mclk_in = 1'b0;
    logic            nrst_in = 1'b0;
    logic [3:0]      addr_in = 4'h0;
    logic [31:0]     wr_data_in = 32'h0;
    logic            wr_in = 1'b0;
    logic            rd_in = 1'b0;
    logic [31:0]     rd_data_out, d;
    // Command pins; remote ones come from the partner
    logic            front_on_in = 1'b0, front_off_in = 1'b0, mute_in = 1'b0;
    logic            failsafe_ok_in = 1'b1, interlock_ok_in = 1'b1;
    logic            remote_lvl1_in, remote_lvl2_in, fault_reset_in;
    // Sensing inputs
    logic            foldback_req_in, exciter_reduce_in, refl_gradual_in, refl_emer_in;
    logic            adc_clip_in;
    logic [31:0]     ps_fault_in, pa_fault_in, pa_manual_off_in, ps_manual_off_in;
    logic [7:0]      heatsink_max_in, surge_dv_in;
    logic [8:0]      mod_pct_in;
    logic [2:0][8:0] phase_v_in;
    logic [2:0]      blower_idle_in, phase_flag_out, blower_flag_out;
    logic [1:0]      aux_fault_in, rf_level_out;
    // Status terminals
    logic            level_one_indicator_out, level_two_indicator_out, off_ind_out, mute_ind_out;
    logic            failsafe_ind_out, interlock_ind_out, fault_summary_out, tx_on_out;
    logic            power_reduction_flag_out, exciter_fault_flag_out, amplifier_fault_flag_out;
    logic            supply_module_fault_flag_out, high_reflection_flag_out, heatsink_hot_flag_out;
    logic            output_short_open_flag_out, audio_overload_flag_out, surge_indicator_out;
    logic            module_service_indicator_out, aux_supply_a_flag_out, aux_supply_b_flag_out;
    logic            rf_zero_out, rf_reduce_out;
    int              n_errors = 0, n_compared = 0, cycles = 0;
    logic [16:0]     exp_f;
    // Flag bit latched by each cause in the sweep
    localparam int FBIT [16] = '{1, 2, 3, 4, 5, 7, 8, 8, 9, 10, 11, 12, 13, 14, 15, 16};

    // Short retry window: 3 ticks of 4 cycles
    tsl_top #(.TICK_CYCLES(4), .RETRY_GAP_MS(3)) u_dut (.*);
    tsl_remote #(.HOLD_CYCLES(10)) u_remote (.mclk_in(mclk_in), .fault_reset_out(fault_reset_in),
        .lvl1_out(remote_lvl1_in), .lvl2_out(remote_lvl2_in));

    always #25 mclk_in = ~mclk_in;

    // Cycle ceiling; a hang counts as a mismatch
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Waits edges, then lets their updates land before sampling
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= v;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 v = rd_data_out;
    endtask

    // Front-panel buttons are held long enough to pass the synchroniser
    task automatic press(input bit off);
        @(posedge mclk_in);
        if (off) front_off_in <= 1'b1;
        else front_on_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        front_on_in <= 1'b0;
        front_off_in <= 1'b0;
        settle(6);
    endtask

    // Healthy readings on every sensing input
    task automatic idle_causes();
        {foldback_req_in, exciter_reduce_in, refl_gradual_in, refl_emer_in, adc_clip_in} <= 5'h0;
        {ps_fault_in, pa_fault_in, pa_manual_off_in, ps_manual_off_in} <= 128'h0;
        {blower_idle_in, aux_fault_in} <= 5'h0;
        heatsink_max_in <= 8'h19;
        mod_pct_in <= 9'h064;
        surge_dv_in <= 8'h00;
        phase_v_in <= {3{9'h0e6}};
    endtask

    initial begin
        idle_causes();
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        settle(8);
        `CHK("off", 1'b1, off_ind_out)
        rd(4'h4, d); `CHK("flags", 32'h0, d)
        rd(4'hc, d); `CHK("unmapped", 32'h0, d)
        press(0);
        `CHK("on", 1'b1, tx_on_out)
        `CHK("off", 1'b0, off_ind_out)
        `CHK("lvl1", 1'b1, level_one_indicator_out)
        // Remote selection is refused until remote control is enabled
        u_remote.select_level(2); settle(6);
        `CHK("lvl2", 1'b0, level_two_indicator_out)
        wr(4'h0, 32'h1); rd(4'h0, d); `CHK("ctrl", 32'h1, d)
        u_remote.select_level(2); settle(6);
        `CHK("lvl2", 1'b1, level_two_indicator_out)
        `CHK("lvl1", 1'b0, level_one_indicator_out)
        @(posedge mclk_in) mute_in <= 1'b1; settle(8);
        `CHK("mute", 1'b1, mute_ind_out)
        `CHK("rfzero", 1'b1, rf_zero_out)
        @(posedge mclk_in) mute_in <= 1'b0; settle(8);
        `CHK("mute", 1'b0, mute_ind_out)
        `CHK("rfzero", 1'b0, rf_zero_out)
        @(posedge mclk_in) failsafe_ok_in <= 1'b0; settle(8);
        `CHK("failsafe", 1'b1, failsafe_ind_out)
        `CHK("rfzero", 1'b1, rf_zero_out)
        @(posedge mclk_in) failsafe_ok_in <= 1'b1; settle(8);
        `CHK("rfzero", 1'b0, rf_zero_out)
        `CHK("level", 2'h2, rf_level_out)
        // Every reading exactly at its limit is still healthy
        @(posedge mclk_in);
        heatsink_max_in <= 8'h55;
        mod_pct_in <= 9'h096;
        surge_dv_in <= 8'h3e;
        phase_v_in <= {9'h109, 9'h0c0, 9'h0e6};
        settle(3);
        rd(4'h4, d); `CHK("flags", 32'h0, d)
        `CHK("surge", 1'b0, surge_indicator_out)
        @(posedge mclk_in) surge_dv_in <= 8'h3f; settle(2);
        `CHK("surge", 1'b1, surge_indicator_out)
        @(posedge mclk_in) idle_causes(); settle(2);
        `CHK("surge", 1'b0, surge_indicator_out)
        // One-cycle causes, one at a time; each latch must hold afterwards
        exp_f = 17'h0;
        for (int k = 0; k < 16; k++) begin
            @(posedge mclk_in);
            case (k)
                0: foldback_req_in <= 1'b1;
                1: exciter_reduce_in <= 1'b1;
                2: ps_fault_in <= 32'h80000000;
                3: pa_fault_in <= 32'h00010000;
                4: refl_gradual_in <= 1'b1;
                5: heatsink_max_in <= 8'h56;
                6: adc_clip_in <= 1'b1;
                7: mod_pct_in <= 9'h097;
                8, 9, 10: phase_v_in[k-8] <= (k == 9) ? 9'h10a : 9'h0bf;
                11, 12, 13: blower_idle_in <= 3'h1 << (k - 11);
                default: aux_fault_in <= 2'h1 << (k - 14);
            endcase
            @(posedge mclk_in) idle_causes();
            exp_f = exp_f | (17'h1 << FBIT[k]) | 17'h1;
            if (k == 1 || k == 4) begin
                exp_f[1] = 1'b1;
            end
            rd(4'h4, d);
            `CHK("flags", {15'h0, exp_f}, d)
        end
        `CHK("summary", 1'b1, fault_summary_out)
        `CHK("reduce", 1'b1, rf_reduce_out)
        `CHK("phase", 3'h7, phase_flag_out)
        `CHK("blower", 3'h7, blower_flag_out)
        `CHK("auxb", 1'b1, aux_supply_b_flag_out)
        // The flag terminals themselves, not only the register copy
        d = {24'h0, power_reduction_flag_out, exciter_fault_flag_out,
             supply_module_fault_flag_out, amplifier_fault_flag_out, high_reflection_flag_out,
             heatsink_hot_flag_out, audio_overload_flag_out, aux_supply_a_flag_out};
        `CHK("flag pins", 32'hff, d)
        @(posedge mclk_in) pa_manual_off_in <= 32'h20; settle(3);
        `CHK("service", 1'b1, module_service_indicator_out)
        // A supply module alone must hold the indicator up as well
        @(posedge mclk_in) pa_manual_off_in <= 32'h0;
        ps_manual_off_in <= 32'h1; settle(3);
        `CHK("service", 1'b1, module_service_indicator_out)
        @(posedge mclk_in) idle_causes(); settle(3);
        `CHK("service", 1'b0, module_service_indicator_out)
        u_remote.request_reset(); settle(3);
        rd(4'h4, d); `CHK("flags", 32'h0, d)
        `CHK("reduce", 1'b0, rf_reduce_out)
        // Phase limits follow the selected nominal voltage
        wr(4'h0, 32'h3);
        // Readings move at the edge that takes the write, so no cycle mixes ranges
        phase_v_in <= {9'h1cc, 9'h14c, 9'h190}; settle(3);
        rd(4'h4, d); `CHK("flags", 32'h0, d)
        wr(4'h0, 32'h1); settle(3);
        rd(4'h4, d); `CHK("flags", 32'he01, d)
        @(posedge mclk_in) idle_causes();
        wr(4'h0, 32'h5); settle(3);
        rd(4'h4, d); `CHK("flags", 32'h0, d)
        @(posedge mclk_in) interlock_ok_in <= 1'b0; settle(8);
        `CHK("interlock", 1'b1, interlock_ind_out)
        `CHK("on", 1'b0, tx_on_out)
        `CHK("off", 1'b1, off_ind_out)
        press(0); `CHK("on", 1'b0, tx_on_out)
        @(posedge mclk_in) interlock_ok_in <= 1'b1; settle(8);
        `CHK("on", 1'b0, tx_on_out)
        u_remote.select_level(1); settle(6);
        `CHK("on", 1'b1, tx_on_out)
        `CHK("lvl1", 1'b1, level_one_indicator_out)
        // Off alone keeps a latch; the following on clears it
        @(posedge mclk_in) blower_idle_in <= 3'h2;
        @(posedge mclk_in) idle_causes();
        press(1); `CHK("blower", 3'h2, blower_flag_out)
        press(0); `CHK("blower", 3'h0, blower_flag_out)
        // Output short three times: two retries, then it stays off
        for (int r = 0; r < 3; r++) begin
            @(posedge mclk_in) refl_emer_in <= 1'b1;
            @(posedge mclk_in) refl_emer_in <= 1'b0;
            settle(3);
            `CHK("on", 1'b0, tx_on_out)
            settle(30);
            `CHK("on", (r < 2), tx_on_out)
            `CHK("emer", 1'b1, output_short_open_flag_out)
        end
        `CHK("off", 1'b1, off_ind_out)
        // Off, level one kept, both retries used
        rd(4'h8, d);
        `CHK("state", 32'h24, d)
        give_verdict();
    end
endmodule // tsl_top_test

`default_nettype wire
